// ---- rtl/cisr_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module cisr_top #(
    parameter int NUM_OUT = 6,
    parameter int NUM_SEL = 6
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PIN_SELECT_MODE,
    input wire logic [1:0] INPUT_SOURCE_SELECT_PINS,
    input wire logic [1:0] REG_SOURCE_SELECT,
    input wire logic [2:0] REF_CLKS,
    input wire logic [cisr_pkg::NUM_SRC-1:0] SRC_CLKS,
    input wire logic RECAL_START,
    input wire logic PLL_LOCK,
    input wire cisr_pkg::cisr_out_cfg_s [NUM_OUT-1:0] OUT_CFG,
    input wire logic [2:0] SEL_SRC [NUM_SEL],
    output logic [1:0] ACTIVE_SOURCE,
    output logic RECAL_BUSY,
    output logic OUTPUTS_ACTIVE,
    output logic [NUM_OUT-1:0] TRUE_OUTPUT_PIN,
    output logic [NUM_OUT-1:0] COMPLEMENT_OUTPUT_PIN,
    output logic [NUM_OUT-1:0] DIFF_MODE,
    output logic [NUM_OUT-1:0] HCSL_TERM_85
);
    import cisr_pkg::*;

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // Every variant offers six selection slots: six single outputs, four
    // singles plus two banks, or two singles plus four banks
    generate
        if (NUM_OUT != 6 && NUM_OUT != 8 && NUM_OUT != 12) begin : g_bad_out
            $error("NUM_OUT must be 6, 8 or 12");
        end
        if (NUM_SEL != 6) begin : g_bad_sel
            $error("NUM_SEL must be 6");
        end
        if (NUM_SRC != 8) begin : g_bad_src
            $error("NUM_SRC must be 8");
        end
    endgenerate

    // ==========================================================
    // Reference selection
    // ==========================================================
    logic [1:0] pin_sync1, pin_sync2;
    logic [2:0] ref_sync1, ref_sync2, ref_sync3;
    logic [1:0] next_source;
    logic [1:0] act_src;

    // Select pins come from the board and are asynchronous; two flops before use
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pin_sync1 <= 2'h0;
            pin_sync2 <= 2'h0;
        end else begin
            pin_sync1 <= INPUT_SOURCE_SELECT_PINS;
            pin_sync2 <= pin_sync1;
        end
    end

    // The third stage only feeds edge detection, never the source path
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ref_sync1 <= 3'h0;
            ref_sync2 <= 3'h0;
            ref_sync3 <= 3'h0;
        end else begin
            ref_sync1 <= REF_CLKS;
            ref_sync2 <= ref_sync1;
            ref_sync3 <= ref_sync2;
        end
    end

    // Switching is immediate: no hitless change, phase may jump
    always_comb begin
        next_source = PIN_SELECT_MODE ? pin_sync2 : REG_SOURCE_SELECT;
        if (next_source == 2'h3) begin
            next_source = IN_XTAL;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            act_src <= IN_XTAL;
        end else begin
            act_src <= next_source;
        end
    end

    // ==========================================================
    // Reference presence and recalibration
    // ==========================================================
    logic ref_edge;
    logic [$clog2(REF_TIMEOUT_CYC+1)-1:0] quiet_cnt;
    logic ref_alive;
    logic seen_ref;
    logic recal;
    logic [1:0] warm;

    // The sync chain resets low, so a reference stuck high would look like an
    // edge just after reset; edges count only once the chain holds real samples
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            warm <= 2'h0;
        end else if (warm != 2'h3) begin
            warm <= warm + 2'h1;
        end
    end

    // A reference that stops later is not acted on: only power-up presence matters
    assign ref_edge = (warm == 2'h3) && (ref_sync2[act_src] ^ ref_sync3[act_src]);

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            quiet_cnt <= '0;
            ref_alive <= 1'b0;
        end else if (ref_edge) begin
            quiet_cnt <= '0;
            ref_alive <= 1'b1;
        end else if (quiet_cnt == ($clog2(REF_TIMEOUT_CYC+1))'(REF_TIMEOUT_CYC)) begin
            ref_alive <= 1'b0;
        end else begin
            quiet_cnt <= quiet_cnt + 1'b1;
        end
    end

    // Latched once: a missing clock at power-up keeps outputs off
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            seen_ref <= 1'b0;
        end else if (ref_alive) begin
            seen_ref <= 1'b1;
        end
    end

    // Small ppm changes need no recalibration; only host start counts
    // A start wins over a lock seen in the same cycle, so a new recalibration is
    // never lost behind the tail of the previous one
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            recal <= 1'b0;
        end else if (RECAL_START) begin
            recal <= 1'b1;
        end else if (recal && PLL_LOCK) begin
            recal <= 1'b0;
        end
    end

    logic run;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            run <= 1'b0;
        end else begin
            run <= seen_ref && !recal && !RECAL_START && PLL_LOCK;
        end
    end

    // ==========================================================
    // Status outputs
    // ==========================================================
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ACTIVE_SOURCE <= IN_XTAL;
        end else begin
            ACTIVE_SOURCE <= act_src;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RECAL_BUSY <= 1'b0;
        end else begin
            RECAL_BUSY <= recal;
        end
    end

    // Lags the pins by nothing: both are taken from the same run value
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            OUTPUTS_ACTIVE <= 1'b0;
        end else begin
            OUTPUTS_ACTIVE <= run;
        end
    end

    // ==========================================================
    // Cross point, dividers and drivers
    // ==========================================================
    logic [NUM_SEL-1:0] sel_clk;
    logic [NUM_SRC-1:0] src_vec;

    always_comb begin
        src_vec = SRC_CLKS;
        src_vec[SRC_REF] = ref_sync2[act_src];
    end

    genvar s;
    generate
        for (s = 0; s < NUM_SEL; s++) begin : g_sel
            assign sel_clk[s] = src_vec[SEL_SRC[s]];
        end
    endgenerate

    // Slot that feeds an output: singles first, then the shared banks
    function automatic int slot_of(int out_idx);
        int nsingle;
        nsingle = (NUM_OUT == 6) ? 6 : (NUM_OUT == 8) ? 4 : 2;
        if (out_idx < nsingle) begin
            return out_idx;
        end else if (NUM_OUT == 12) begin
            return nsingle + ((out_idx - nsingle) * 4) / 10;
        end else begin
            return nsingle + (out_idx - nsingle) / 2;
        end
    endfunction

    // A source that stops simply freezes its dividers; the ratio phase is not
    // realigned when it returns
    genvar o;
    generate
        for (o = 0; o < NUM_OUT; o++) begin : g_out
            localparam int BIDX = slot_of(o);
            logic src_clk, src_d, div_clk;
            logic [5:0] cnt;
            logic [5:0] div;
            assign src_clk = sel_clk[BIDX];
            // Zero is illegal; treat as divide-by-1
            assign div = (OUT_CFG[o].div == 6'h00) ? DIV_RESET : OUT_CFG[o].div;

            // Previous source sample, for rising edge detection
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    src_d <= 1'b0;
                end else begin
                    src_d <= src_clk;
                end
            end

            // High for the first part of each ratio, low for the rest; odd ratios
            // give the shorter part to the high phase
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    cnt <= 6'h00;
                    div_clk <= 1'b0;
                end else begin
                    if (div == DIV_RESET) begin
                        div_clk <= src_clk;
                        cnt <= 6'h00;
                    end else if (src_clk && !src_d) begin
                        if (cnt >= div - 6'h01) begin
                            cnt <= 6'h00;
                            div_clk <= 1'b1;
                        end else begin
                            cnt <= cnt + 6'h01;
                            if (cnt + 6'h01 >= (div >> 1)) begin
                                div_clk <= 1'b0;
                            end
                        end
                    end
                end
            end

            // Format and termination follow configuration
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    DIFF_MODE[o] <= 1'b0;
                    HCSL_TERM_85[o] <= 1'b0;
                end else begin
                    DIFF_MODE[o] <= OUT_CFG[o].diff_fmt;
                    HCSL_TERM_85[o] <= OUT_CFG[o].hcsl_85;
                end
            end

            // Stopped pins sit low on both legs, so receivers see no runt edges
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    TRUE_OUTPUT_PIN[o] <= 1'b0;
                    COMPLEMENT_OUTPUT_PIN[o] <= 1'b0;
                end else begin
                    if (!run) begin
                        TRUE_OUTPUT_PIN[o] <= 1'b0;
                        COMPLEMENT_OUTPUT_PIN[o] <= 1'b0;
                    end else if (OUT_CFG[o].diff_fmt) begin
                        TRUE_OUTPUT_PIN[o] <= div_clk;
                        COMPLEMENT_OUTPUT_PIN[o] <= !div_clk;
                    end else begin
                        TRUE_OUTPUT_PIN[o] <= div_clk ^ OUT_CFG[o].cmos_inv_true;
                        COMPLEMENT_OUTPUT_PIN[o] <= div_clk ^ OUT_CFG[o].cmos_inv_comp;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- rtl/cisr_pkg.sv ----
package cisr_pkg;
    localparam int NUM_SRC = 8;
    localparam logic [2:0] SRC_FSYN0 = 3'h0;
    localparam logic [2:0] SRC_FSYN1 = 3'h1;
    localparam logic [2:0] SRC_REF = 3'h2;
    localparam logic [2:0] SRC_INT0 = 3'h3;
    localparam logic [5:0] DIV_RESET = 6'h01;
    localparam logic [5:0] DIV_MAX = 6'h3f;
    localparam logic [1:0] IN_XTAL = 2'h0;
    localparam logic [1:0] IN_CLK2 = 2'h1;
    localparam logic [1:0] IN_CLK3 = 2'h2;
    localparam int REF_TIMEOUT_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic diff_fmt;
        logic hcsl_85;
        logic cmos_inv_true;
        logic cmos_inv_comp;
        logic [2:0] src;
        logic [5:0] div;
    } cisr_out_cfg_s;
endpackage

// ---- tb/cisr_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module cisr_chk import cisr_pkg::*; #(parameter int NUM_OUT = 6) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PIN_SELECT_MODE,
    input wire logic [1:0] INPUT_SOURCE_SELECT_PINS,
    input wire logic [1:0] REG_SOURCE_SELECT,
    input wire logic RECAL_START,
    input wire logic PLL_LOCK,
    input wire cisr_pkg::cisr_out_cfg_s [NUM_OUT-1:0] OUT_CFG,
    input wire logic [1:0] ACTIVE_SOURCE,
    input wire logic RECAL_BUSY,
    input wire logic OUTPUTS_ACTIVE,
    input wire logic [NUM_OUT-1:0] TRUE_OUTPUT_PIN,
    input wire logic [NUM_OUT-1:0] COMPLEMENT_OUTPUT_PIN,
    input wire logic [NUM_OUT-1:0] DIFF_MODE,
    input wire logic [NUM_OUT-1:0] HCSL_TERM_85
);
    // ============================================================
    // Checks
    logic [2*NUM_OUT-1:0] fmt;
    logic [NUM_OUT-1:0] comp;
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            fmt[i] = OUT_CFG[i].hcsl_85;
            fmt[NUM_OUT+i] = OUT_CFG[i].diff_fmt;
            comp[i] = OUT_CFG[i].diff_fmt ? !TRUE_OUTPUT_PIN[i] :
                TRUE_OUTPUT_PIN[i] ^ OUT_CFG[i].cmos_inv_true ^ OUT_CFG[i].cmos_inv_comp;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_busy_set; RECAL_START |-> ##2 RECAL_BUSY; endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy not set");
    property p_busy_clr; RECAL_BUSY && PLL_LOCK && !RECAL_START |-> ##2 !RECAL_BUSY; endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");
    property p_restart;
        $fell(RECAL_BUSY) && $past(PLL_LOCK) && !$past(RECAL_START) |=> OUTPUTS_ACTIVE;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_hold_off; RECAL_BUSY |-> !OUTPUTS_ACTIVE; endproperty
    a_hold_off: assert property (p_hold_off) else $error("active while busy");
    property p_lock_first;
        $rose(OUTPUTS_ACTIVE) |-> $past(PLL_LOCK, 2) && !$past(RECAL_BUSY);
    endproperty
    a_lock_first: assert property (p_lock_first) else $error("active without lock");
    property p_pins_off; !OUTPUTS_ACTIVE |-> (TRUE_OUTPUT_PIN | COMPLEMENT_OUTPUT_PIN) == '0; endproperty
    a_pins_off: assert property (p_pins_off) else $error("pins run while stopped");
    property p_fmt; !$past(RST) |-> {DIFF_MODE, HCSL_TERM_85} == $past(fmt); endproperty
    a_fmt: assert property (p_fmt) else $error("format copy wrong");
    property p_comp; ($stable(OUT_CFG) && OUTPUTS_ACTIVE)[*4] |-> COMPLEMENT_OUTPUT_PIN == comp; endproperty
    a_comp: assert property (p_comp) else $error("complement pin wrong");
    property p_reg_sel; (!PIN_SELECT_MODE && $stable(REG_SOURCE_SELECT))[*4] |->
        ACTIVE_SOURCE == ((REG_SOURCE_SELECT == 2'h3) ? 2'h0 : REG_SOURCE_SELECT); endproperty
    a_reg_sel: assert property (p_reg_sel) else $error("register select wrong");
    property p_pin_sel; (PIN_SELECT_MODE && $stable(INPUT_SOURCE_SELECT_PINS))[*5] |->
        ACTIVE_SOURCE == ((INPUT_SOURCE_SELECT_PINS == 2'h3) ? 2'h0 : INPUT_SOURCE_SELECT_PINS);
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("pin select wrong");
endmodule
bind cisr_top cisr_chk #(.NUM_OUT(NUM_OUT)) u_chk (.CORE_CLK, .RST, .PIN_SELECT_MODE,
    .INPUT_SOURCE_SELECT_PINS, .REG_SOURCE_SELECT, .RECAL_START, .PLL_LOCK, .OUT_CFG,
    .ACTIVE_SOURCE, .RECAL_BUSY, .OUTPUTS_ACTIVE, .TRUE_OUTPUT_PIN, .COMPLEMENT_OUTPUT_PIN,
    .DIFF_MODE, .HCSL_TERM_85);
`default_nettype wire

// ---- tb/cisr_clk_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cisr_clk_model (
    input wire logic clk,
    input wire logic ref_on,
    input wire logic recal,
    input wire logic [7:0] lock_wait,
    output logic [2:0] ref_clks,
    output logic [7:0] src_clks,
    output var logic pll_lock
);
    // ============================================================
    // Sources and lock
    logic [15:0] cnt = 16'h0;
    logic [7:0] left = 8'h0;
    initial pll_lock = 1'b0;
    always @(posedge clk) cnt <= cnt + 16'h1;
    // Stopped references stand still, so presence is really absent
    always_comb begin
        for (int i = 0; i < 8; i++) src_clks[i] = (int'(cnt) / (i + 2)) % 2 == 1;
        for (int j = 0; j < 3; j++) ref_clks[j] = ref_on && (int'(cnt) / (j + 3)) % 2 == 1;
    end
    always @(posedge clk) begin
        if (recal) begin
            pll_lock <= 1'b0;
            left <= lock_wait;
        end else if (left != 8'h0) begin
            left <= left - 8'h1;
        end else begin
            pll_lock <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cisr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, pmode = 1'b0, recal = 1'b0, ref_on = 1'b1, lock, busy, oact;
    logic [1:0] pins = 2'h0, rsel = 2'h0, act;
    logic [2:0] refc;
    logic [7:0] srcc, lwait = 8'h02;
    logic [2:0] sel [6] = '{default: 3'h0};
    cisr_out_cfg_s [5:0] cfg = '0;
    logic [5:0] tp, cp, dm, h85, ed, eh;
    int failures = 0, tests_run = 0;
    cisr_top dut (.CORE_CLK(clk), .RST(rst), .PIN_SELECT_MODE(pmode),
        .INPUT_SOURCE_SELECT_PINS(pins), .REG_SOURCE_SELECT(rsel), .REF_CLKS(refc),
        .SRC_CLKS(srcc), .RECAL_START(recal), .PLL_LOCK(lock), .OUT_CFG(cfg), .SEL_SRC(sel),
        .ACTIVE_SOURCE(act), .RECAL_BUSY(busy), .OUTPUTS_ACTIVE(oact), .TRUE_OUTPUT_PIN(tp),
        .COMPLEMENT_OUTPUT_PIN(cp), .DIFF_MODE(dm), .HCSL_TERM_85(h85));
    cisr_clk_model pm (.clk(clk), .ref_on(ref_on), .recal(recal), .lock_wait(lwait),
        .ref_clks(refc), .src_clks(srcc), .pll_lock(lock));
    initial forever #2.5 clk = ~clk;
    // ============================================================
    // Helpers
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_on(int lim);
        for (int t = 0; t < lim && oact !== 1'b1; t++) @(negedge clk);
        chk("outputs_active", 32'(oact), 32'h1);
        if (oact !== 1'b1) summarize();
    endtask
    function automatic logic [1:0] pick(logic [1:0] c);
        return (c == 2'h3) ? 2'h0 : c;
    endfunction
    function automatic logic srcv(int s);
        return (s == 2) ? refc[rsel] : srcc[s];
    endfunction
    initial begin
        int d, s, o, r, n;
        logic p, q, c;
        void'($urandom(32'ha88d62ef));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        for (int m = 0; m < 8; m++) begin
            pmode = m[2];
            pins = m[1:0];
            rsel = ~m[1:0];
            repeat (8) @(negedge clk);
            chk("active_source", 32'(act), 32'(pick(m[2] ? m[1:0] : ~m[1:0])));
        end
        $display("test source select done");
        pmode = 1'b0;
        for (int k = 0; k < 8; k++) begin
            d = (k == 0) ? 1 : (k == 1) ? 63 : $urandom_range(63, 1);
            s = (k == 2) ? 2 : $urandom_range(7, 0);
            o = $urandom_range(5, 0);
            rsel = 2'($urandom_range(2, 0));
            for (int i = 0; i < 6; i++) begin
                cfg[i] = cisr_out_cfg_s'(13'($urandom));
                sel[i] = 3'($urandom_range(7, 0));
            end
            cfg[o].div = 6'(d);
            sel[o] = 3'(s);
            foreach (ed[i]) {ed[i], eh[i]} = {cfg[i].diff_fmt, cfg[i].hcsl_85};
            wait_on(1000);
            repeat (8) @(negedge clk);
            {r, n, p, q} = {32'h0, 32'h0, srcv(s), tp[o]};
            for (int t = 0; t < 20000 && r < 4 * d; t++) begin
                @(negedge clk);
                c = srcv(s);
                r += int'(c && !p);
                n += int'(tp[o] && !q);
                {p, q} = {c, tp[o]};
            end
            chk("source_edges", r, 4 * d);
            if (r < 4 * d) summarize();
            chk("output_edges_ok", 32'(n >= 3 && n <= 5), 32'h1);
            chk("diff_mode", 32'(dm), 32'(ed));
            chk("hcsl_85", 32'(h85), 32'(eh));
        end
        $display("test divider and format done");
        for (int j = 0; j < 2; j++) begin
            lwait = j ? 8'hc8 : 8'h02;
            recal = 1'b1;
            @(negedge clk);
            recal = 1'b0;
            @(negedge clk);
            chk("recal_busy", 32'(busy), 32'h1);
            chk("outputs_off", 32'({oact, tp, cp}), 32'h0);
            wait_on(600);
            chk("recal_done", 32'(busy), 32'h0);
        end
        $display("test recalibration done");
        ref_on = 1'b0;
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (400) @(negedge clk);
        chk("no_ref_outputs", 32'({oact, tp, cp}), 32'h0);
        $display("test missing reference done");
        summarize();
    end
endmodule
`default_nettype wire
